// ==== hw/terminal_mux_pkg.sv ====
// Purpose: Constants for the output terminal function multiplexer
// Assumes: Selector codes are 16-bit unsigned values
// Notes:   Register offsets are word indices on the plain register port
package terminal_mux_pkg;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned CODE_W = 16;

   // ********************************
   // Register offsets
   // ********************************
   localparam logic [3:0] OFS_RUN_SEL    = 4'h0;
   localparam logic [3:0] OFS_RELAY_SEL  = 4'h1;
   localparam logic [3:0] OFS_SAFETY_SEL = 4'h2;
   localparam logic [3:0] OFS_GATE       = 4'h3;
   localparam logic [3:0] OFS_STATUS     = 4'h4;
   localparam logic [3:0] OFS_TERM       = 4'h5;

   // ********************************
   // Reset values
   // ********************************
   localparam logic [15:0] RST_RUN_SEL    = 16'h0000;
   localparam logic [15:0] RST_RELAY_SEL  = 16'h0063;
   localparam logic [15:0] RST_SAFETY_SEL = 16'h0050;
   localparam logic [15:0] RST_GATE       = 16'h0000;

   // ********************************
   // Code classes
   // ********************************
   localparam logic [15:0] SINK_OFFSET  = 16'h0064;
   localparam logic [15:0] SINK_LAST    = 16'h00c7;
   localparam logic [15:0] CODE_NONE    = 16'h270f;
   localparam logic [15:0] CODE_AVG_MON = 16'h005d;

   // Number of condition inputs, one bit per function number 0..99
   localparam int unsigned NUM_FUNC = 100;

endpackage : terminal_mux_pkg

// ==== hw/terminal_route.sv ====
// Purpose: Decode one selector code into a terminal level
// Assumes: Conditions are synchronous to the clock
// Notes:   Pure combinational decode, registered by the parent
`timescale 1ns/1ps
`default_nettype none
module terminal_route (
   input  wire logic [15:0] code_i,
   input  wire logic [99:0] cond_i,
   output logic             conduct_o
);

   logic [15:0] func_num;
   logic        sink_sel;

   // Split code into function number and polarity
   always_comb begin
      sink_sel = (code_i >= terminal_mux_pkg::SINK_OFFSET) &&
                 (code_i <= terminal_mux_pkg::SINK_LAST);
      func_num = sink_sel ? (code_i - terminal_mux_pkg::SINK_OFFSET) : code_i;
   end

   // Conduct on true for source, not conduct on true for sink
   always_comb begin
      if (code_i == terminal_mux_pkg::CODE_NONE) begin
         conduct_o = 1'b0;
      end else if (func_num < 16'(terminal_mux_pkg::NUM_FUNC)) begin
         conduct_o = cond_i[func_num[6:0]] ^ sink_sel;
      end else begin
         conduct_o = 1'b0;
      end
   end

endmodule : terminal_route
`default_nettype wire

// ==== hw/output_terminal_function_mux.sv ====
// Purpose: Route internal status conditions to three output terminals
// Assumes: All inputs synchronous to core_clk_i, 20 MHz
// Notes:   Selectors written over a plain register port
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module output_terminal_function_mux (
   input  wire logic                core_clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                clk_en_i,
   // Register port
   input  wire logic [3:0]          reg_addr_i,
   input  wire logic [15:0]         reg_wdata_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   output logic      [15:0]         reg_rdata_o,
   // Conditions
   input  wire logic                running_flag_i,
   input  wire logic                speed_reached_flag_i,
   input  wire logic                stall_active_flag_i,
   input  wire logic                frequency_detect_flag_i,
   input  wire logic                brake_duty_prealarm_i,
   input  wire logic                thermal_prealarm_i,
   input  wire logic                ready_flag_i,
   input  wire logic                current_high_flag_i,
   input  wire logic                current_low_flag_i,
   input  wire logic                loop_low_limit_flag_i,
   input  wire logic                loop_high_limit_flag_i,
   input  wire logic                loop_forward_flag_i,
   input  wire logic                fan_fault_flag_i,
   input  wire logic                heatsink_prealarm_i,
   input  wire logic                powerloss_decel_flag_i,
   input  wire logic                loop_active_flag_i,
   input  wire logic                retry_flag_i,
   input  wire logic                loop_pause_flag_i,
   input  wire logic                safety_stop_flag_i,
   input  wire logic                safety_healthy_flag_i,
   input  wire logic [9:0]          upper_func_i,
   input  wire logic                fault_alarm_flag_i,
   // Terminals, high means conducting
   output logic                     running_terminal_o,
   output logic                     relay_output_terminal_o,
   output logic                     safety_terminal_o
);

   // ********************************
   // Condition vector by function number
   // ********************************
   logic [99:0] cond;

   // upper_func_i bits 0..8 carry functions 90,91,93,95,96,98 and spares
   always_comb begin
      cond     = '0;
      cond[0]  = running_flag_i;
      cond[1]  = speed_reached_flag_i;
      cond[3]  = stall_active_flag_i;
      cond[4]  = frequency_detect_flag_i;
      cond[7]  = brake_duty_prealarm_i;
      cond[8]  = thermal_prealarm_i;
      cond[11] = ready_flag_i;
      cond[12] = current_high_flag_i;
      cond[13] = current_low_flag_i;
      cond[14] = loop_low_limit_flag_i;
      cond[15] = loop_high_limit_flag_i;
      cond[16] = loop_forward_flag_i;
      cond[25] = fan_fault_flag_i;
      cond[26] = heatsink_prealarm_i;
      cond[46] = powerloss_decel_flag_i;
      cond[47] = loop_active_flag_i;
      cond[64] = retry_flag_i;
      cond[70] = loop_pause_flag_i;
      cond[80] = safety_stop_flag_i;
      cond[81] = safety_healthy_flag_i;
      cond[90] = upper_func_i[0];
      cond[91] = upper_func_i[1];
      cond[93] = upper_func_i[3];
      cond[95] = upper_func_i[5];
      cond[96] = upper_func_i[6];
      cond[98] = upper_func_i[8];
      cond[99] = fault_alarm_flag_i;
   end

   // ********************************
   // Permitted code check
   // ********************************
   function automatic logic code_ok(input logic [15:0] code, input logic allow_avg);
      logic [15:0] f;
      f = code;
      if (code >= terminal_mux_pkg::SINK_OFFSET && code <= terminal_mux_pkg::SINK_LAST) begin
         f = code - terminal_mux_pkg::SINK_OFFSET;
      end
      if (code == terminal_mux_pkg::CODE_NONE) begin
         code_ok = 1'b1;
      end else if (code > terminal_mux_pkg::SINK_LAST) begin
         code_ok = 1'b0;
      end else begin
         unique case (f)
            16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0007, 16'h0008,
            16'h000b, 16'h000c, 16'h000d, 16'h000e, 16'h000f, 16'h0010,
            16'h0019, 16'h001a, 16'h002e, 16'h002f, 16'h0040, 16'h0046,
            16'h0050, 16'h0051, 16'h005a, 16'h005b, 16'h005f, 16'h0060,
            16'h0062, 16'h0063: code_ok = 1'b1;
            16'h005d: code_ok = allow_avg;
            default: code_ok = 1'b0;
         endcase
      end
   endfunction : code_ok

   // ********************************
   // Registers
   // ********************************
   logic [15:0] run_sel_r;
   logic [15:0] relay_sel_r;
   logic [15:0] safety_sel_r;
   logic [15:0] gate_r;
   logic        sel_open;
   logic [15:0] rdata_nxt;

   assign sel_open = (gate_r == 16'h0000);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gate_r <= terminal_mux_pkg::RST_GATE;
      end else if (clk_en_i && reg_wr_i && reg_addr_i == terminal_mux_pkg::OFS_GATE) begin
         gate_r <= reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_sel_r <= terminal_mux_pkg::RST_RUN_SEL;
      end else if (clk_en_i && reg_wr_i && sel_open &&
                   reg_addr_i == terminal_mux_pkg::OFS_RUN_SEL &&
                   code_ok(reg_wdata_i, 1'b1)) begin
         run_sel_r <= reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         relay_sel_r <= terminal_mux_pkg::RST_RELAY_SEL;
      end else if (clk_en_i && reg_wr_i && sel_open &&
                   reg_addr_i == terminal_mux_pkg::OFS_RELAY_SEL &&
                   code_ok(reg_wdata_i, 1'b0)) begin
         relay_sel_r <= reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         safety_sel_r <= terminal_mux_pkg::RST_SAFETY_SEL;
      end else if (clk_en_i && reg_wr_i && sel_open &&
                   reg_addr_i == terminal_mux_pkg::OFS_SAFETY_SEL &&
                   code_ok(reg_wdata_i, 1'b1)) begin
         safety_sel_r <= reg_wdata_i;
      end
   end

   // ********************************
   // Terminal routing
   // ********************************
   logic run_nxt;
   logic relay_nxt;
   logic safety_nxt;

   terminal_route u_route_run (
      .code_i    (run_sel_r),
      .cond_i    (cond),
      .conduct_o (run_nxt)
   );

   terminal_route u_route_relay (
      .code_i    (relay_sel_r),
      .cond_i    (cond),
      .conduct_o (relay_nxt)
   );

   terminal_route u_route_safety (
      .code_i    (safety_sel_r),
      .cond_i    (cond),
      .conduct_o (safety_nxt)
   );

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         running_terminal_o      <= 1'b0;
         relay_output_terminal_o <= 1'b0;
         safety_terminal_o       <= 1'b0;
      end else if (clk_en_i) begin
         running_terminal_o      <= run_nxt;
         relay_output_terminal_o <= relay_nxt;
         safety_terminal_o       <= safety_nxt;
      end
   end

   // ********************************
   // Read port
   // ********************************
   always_comb begin
      rdata_nxt = 16'h0000;
      unique case (reg_addr_i)
         terminal_mux_pkg::OFS_RUN_SEL:    rdata_nxt = run_sel_r;
         terminal_mux_pkg::OFS_RELAY_SEL:  rdata_nxt = relay_sel_r;
         terminal_mux_pkg::OFS_SAFETY_SEL: rdata_nxt = safety_sel_r;
         terminal_mux_pkg::OFS_GATE:       rdata_nxt = gate_r;
         terminal_mux_pkg::OFS_STATUS:     rdata_nxt = {15'h0000, sel_open};
         terminal_mux_pkg::OFS_TERM:       rdata_nxt = {13'h0000, safety_terminal_o,
                                                        relay_output_terminal_o,
                                                        running_terminal_o};
         default:                          rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (clk_en_i) begin
         reg_rdata_o <= reg_rd_i ? rdata_nxt : 16'h0000;
      end
   end

   // ********************************
   // Checks
   // ********************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_sel_write(logic [3:0] a);
      clk_en_i && reg_wr_i && reg_addr_i == a;
   endsequence

   chk_gate_blocks_write: assert property (
      s_sel_write(terminal_mux_pkg::OFS_RUN_SEL) and !sel_open |=> $stable(run_sel_r))
      else $error("Selector changed while gate closed");
   chk_relay_refuse_avg: assert property (
      s_sel_write(terminal_mux_pkg::OFS_RELAY_SEL) and
      (reg_wdata_i == 16'h005d || reg_wdata_i == 16'h00c1) |=> $stable(relay_sel_r))
      else $error("Relay accepted average monitor code");
   chk_bad_code_kept: assert property (
      s_sel_write(terminal_mux_pkg::OFS_SAFETY_SEL) and reg_wdata_i == 16'h00c8
      |=> $stable(safety_sel_r))
      else $error("Illegal code accepted");
   chk_good_code_taken: assert property (
      s_sel_write(terminal_mux_pkg::OFS_RUN_SEL) and sel_open and reg_wdata_i == 16'h000b
      |=> run_sel_r == 16'h000b)
      else $error("Legal code not stored");
   chk_source_run: assert property (
      clk_en_i && run_sel_r == 16'h0000 |=> running_terminal_o == $past(running_flag_i))
      else $error("Source running route wrong");
   chk_sink_relay: assert property (
      clk_en_i && relay_sel_r == 16'h00c7 |=>
      relay_output_terminal_o == !$past(fault_alarm_flag_i))
      else $error("Sink relay polarity wrong");
   chk_none_idle: assert property (
      clk_en_i && safety_sel_r == terminal_mux_pkg::CODE_NONE |=> !safety_terminal_o)
      else $error("No-function terminal conducted");
   chk_safety_route: assert property (
      clk_en_i && safety_sel_r == 16'h0050 |=> safety_terminal_o == $past(safety_stop_flag_i))
      else $error("Safety route wrong");

   // ********************************
   // Freeze, gate, readback, code and routing checks
   // ********************************
   sequence s_frozen;
      !clk_en_i;
   endsequence

   sequence s_read_done;
      clk_en_i && reg_rd_i ##1 clk_en_i && !reg_rd_i;
   endsequence

   sequence s_ready_write;
      s_sel_write(terminal_mux_pkg::OFS_RUN_SEL) and sel_open and reg_wdata_i == 16'h000b;
   endsequence

   chk_freeze_select: assert property (
      s_frozen |=> $stable(run_sel_r) && $stable(relay_sel_r) &&
      $stable(safety_sel_r) && $stable(gate_r))
      else $error("Selector changed while frozen");
   chk_freeze_terminal: assert property (
      s_frozen |=> $stable(running_terminal_o) && $stable(relay_output_terminal_o) &&
      $stable(safety_terminal_o))
      else $error("Terminal changed while frozen");
   chk_read_clears: assert property (
      s_read_done |=> reg_rdata_o == 16'h0000)
      else $error("Read data stood too long");
   chk_read_select: assert property (
      clk_en_i && reg_rd_i && reg_addr_i == terminal_mux_pkg::OFS_RUN_SEL
      |=> reg_rdata_o == $past(run_sel_r))
      else $error("Running selector readback wrong");
   chk_status_read: assert property (
      clk_en_i && reg_rd_i && reg_addr_i == terminal_mux_pkg::OFS_STATUS
      |=> reg_rdata_o == {15'h0000, $past(gate_r) == 16'h0000})
      else $error("Gate status readback wrong");
   chk_gate_blocks_relay: assert property (
      s_sel_write(terminal_mux_pkg::OFS_RELAY_SEL) and !sel_open |=> $stable(relay_sel_r))
      else $error("Relay selector changed while gate closed");
   chk_gate_blocks_safety: assert property (
      s_sel_write(terminal_mux_pkg::OFS_SAFETY_SEL) and !sel_open |=> $stable(safety_sel_r))
      else $error("Safety selector changed while gate closed");
   chk_refused_run: assert property (
      s_sel_write(terminal_mux_pkg::OFS_RUN_SEL) and reg_wdata_i == 16'h00c8
      |=> $stable(run_sel_r))
      else $error("Running selector took illegal code");
   chk_relay_no_avg: assert property (
      relay_sel_r != 16'h005d && relay_sel_r != 16'h00c1)
      else $error("Relay selector holds refused code");
   chk_relay_alarm: assert property (
      clk_en_i && relay_sel_r == 16'h0063
      |=> relay_output_terminal_o == $past(fault_alarm_flag_i))
      else $error("Relay alarm route wrong");
   chk_ready_route: assert property (
      s_ready_write ##1 clk_en_i |=> running_terminal_o == $past(ready_flag_i))
      else $error("Ready route after write wrong");
   chk_none_run: assert property (
      clk_en_i && run_sel_r == terminal_mux_pkg::CODE_NONE |=> !running_terminal_o)
      else $error("No-function running terminal conducted");
   chk_avg_safety: assert property (
      clk_en_i && safety_sel_r == 16'h005d |=> safety_terminal_o == $past(upper_func_i[3]))
      else $error("Safety average monitor route wrong");

endmodule : output_terminal_function_mux
`default_nettype wire

// ==== verif/terminal_reader.sv ====
// Purpose: Far-side equipment reading the three output terminals
// Assumes: High terminal level means the output is conducting
// Notes:   Reports levels as {running, relay, safety}
`timescale 1ns/1ps
`default_nettype none
module terminal_reader (
   input  wire logic       running_terminal_i,
   input  wire logic       relay_terminal_i,
   input  wire logic       safety_terminal_i,
   output logic      [2:0] seen_o
);
   // Equipment only reads the terminals
   assign seen_o = {running_terminal_i, relay_terminal_i, safety_terminal_i};
endmodule : terminal_reader
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the output terminal multiplexer
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Expected values queued by the driver, checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        core_clk_i = 1'b0;
   logic        rst_n_i    = 1'b0;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic        reg_wr_i   = 1'b0;
   logic        reg_rd_i   = 1'b0;
   logic [15:0] reg_rdata_o;
   logic [20:0] cv         = '0;
   logic [9:0]  upper_func = 10'h000;
   logic        run_t, relay_t, safety_t, term_req = 1'b0, rd_d = 1'b0, clk_en = 1'b1;
   logic [2:0]  seen;
   logic [15:0] rd_exp[$];
   logic [2:0]  term_exp[$];
   logic [31:0] rng = 32'd86998;
   int          err_count = 0;
   int          checks    = 0;
   logic [15:0] codes[21] = '{16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0007, 16'h0008,
      16'h000b, 16'h000c, 16'h000d, 16'h000e, 16'h000f, 16'h0010, 16'h0019, 16'h001a,
      16'h002e, 16'h002f, 16'h0040, 16'h0046, 16'h0050, 16'h0051, 16'h0063};

   output_terminal_function_mux u_output_terminal_function_mux (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .running_flag_i(cv[0]), .speed_reached_flag_i(cv[1]), .stall_active_flag_i(cv[2]),
      .frequency_detect_flag_i(cv[3]), .brake_duty_prealarm_i(cv[4]),
      .thermal_prealarm_i(cv[5]), .ready_flag_i(cv[6]), .current_high_flag_i(cv[7]),
      .current_low_flag_i(cv[8]), .loop_low_limit_flag_i(cv[9]),
      .loop_high_limit_flag_i(cv[10]), .loop_forward_flag_i(cv[11]),
      .fan_fault_flag_i(cv[12]), .heatsink_prealarm_i(cv[13]),
      .powerloss_decel_flag_i(cv[14]), .loop_active_flag_i(cv[15]), .retry_flag_i(cv[16]),
      .loop_pause_flag_i(cv[17]), .safety_stop_flag_i(cv[18]),
      .safety_healthy_flag_i(cv[19]), .upper_func_i(upper_func),
      .fault_alarm_flag_i(cv[20]), .running_terminal_o(run_t),
      .relay_output_terminal_o(relay_t), .safety_terminal_o(safety_t));

   terminal_reader u_terminal_reader (
      .running_terminal_i(run_t), .relay_terminal_i(relay_t),
      .safety_terminal_i(safety_t), .seen_o(seen));

   // ********************************
   // Clock, helpers
   // ********************************
   initial begin
      forever #25 core_clk_i = ~core_clk_i;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   task automatic compare(input string name, input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : compare

   task automatic give_verdict();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk_i);
      rd_exp.push_back(e);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
   endtask : rd

   task automatic term(input logic [2:0] e);
      @(posedge core_clk_i);
      term_exp.push_back(e);
      term_req <= 1'b1;
      @(posedge core_clk_i);
      term_req <= 1'b0;
   endtask : term

   // ********************************
   // Monitor
   // ********************************
   always @(posedge core_clk_i) begin
      rd_d <= reg_rd_i;
      if (rd_d) compare("reg_rdata_o", reg_rdata_o, rd_exp.pop_front());
      if (term_req) compare("terminals", {13'h0000, seen}, {13'h0000, term_exp.pop_front()});
   end

   // ********************************
   // Stimulus
   // ********************************
   initial begin
      logic c;
      repeat (16) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      rd(terminal_mux_pkg::OFS_RUN_SEL, 16'h0000);
      rd(terminal_mux_pkg::OFS_RELAY_SEL, 16'h0063);
      rd(terminal_mux_pkg::OFS_SAFETY_SEL, 16'h0050);
      rd(terminal_mux_pkg::OFS_GATE, 16'h0000);
      rd(4'hf, 16'h0000);
      cv <= 21'h140001;
      term(3'b111);
      cv <= 21'h0bfffe;
      term(3'b000);
      for (int i = 0; i < 21; i++) begin
         rng = xs(rng);
         c   = rng[0];
         wr(terminal_mux_pkg::OFS_RUN_SEL, codes[i]);
         wr(terminal_mux_pkg::OFS_RELAY_SEL, codes[i] + 16'h0064);
         wr(terminal_mux_pkg::OFS_SAFETY_SEL, codes[i]);
         cv <= {21{~c}} ^ (21'h1 << i);
         upper_func <= {10{~c}};
         rd(terminal_mux_pkg::OFS_RELAY_SEL, codes[i] + 16'h0064);
         term({c, ~c, c});
      end
      wr(terminal_mux_pkg::OFS_RUN_SEL, 16'h270f);
      wr(terminal_mux_pkg::OFS_SAFETY_SEL, 16'h270f);
      cv <= '1;
      term(3'b000);
      wr(terminal_mux_pkg::OFS_RELAY_SEL, 16'h005d);
      wr(terminal_mux_pkg::OFS_RELAY_SEL, 16'h00c1);
      wr(terminal_mux_pkg::OFS_SAFETY_SEL, 16'h0002);
      wr(terminal_mux_pkg::OFS_SAFETY_SEL, 16'h00c8);
      wr(terminal_mux_pkg::OFS_RUN_SEL, 16'h00c8);
      rd(terminal_mux_pkg::OFS_RELAY_SEL, 16'h00c7);
      rd(terminal_mux_pkg::OFS_SAFETY_SEL, 16'h270f);
      rd(terminal_mux_pkg::OFS_RUN_SEL, 16'h270f);
      wr(terminal_mux_pkg::OFS_SAFETY_SEL, 16'h005d);
      rd(terminal_mux_pkg::OFS_SAFETY_SEL, 16'h005d);
      wr(terminal_mux_pkg::OFS_GATE, 16'h0001);
      rd(terminal_mux_pkg::OFS_STATUS, 16'h0000);
      wr(terminal_mux_pkg::OFS_RUN_SEL, 16'h0001);
      wr(terminal_mux_pkg::OFS_RELAY_SEL, 16'h0001);
      wr(terminal_mux_pkg::OFS_SAFETY_SEL, 16'h0001);
      rd(terminal_mux_pkg::OFS_RUN_SEL, 16'h270f);
      rd(terminal_mux_pkg::OFS_RELAY_SEL, 16'h00c7);
      rd(terminal_mux_pkg::OFS_SAFETY_SEL, 16'h005d);
      wr(terminal_mux_pkg::OFS_GATE, 16'h0000);
      rd(terminal_mux_pkg::OFS_STATUS, 16'h0001);
      wr(terminal_mux_pkg::OFS_RUN_SEL, 16'h0050);
      rd(terminal_mux_pkg::OFS_RUN_SEL, 16'h0050);
      clk_en <= 1'b0;
      wr(terminal_mux_pkg::OFS_RUN_SEL, 16'h0001);
      clk_en <= 1'b1;
      rd(terminal_mux_pkg::OFS_RUN_SEL, 16'h0050);
      for (int i = 0; i < 20; i++) begin
         rng = xs(rng);
         cv <= rng[20:0];
         upper_func <= rng[30:21];
         term({rng[18], ~rng[20], rng[24]});
      end
      repeat (2) @(posedge core_clk_i);
      give_verdict();
   end

   initial begin
      #(4000 * 50);
      err_count++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
